// ===== core/pll_ctl_pkg.sv
// Constants shared by the clock synthesis control block
package pll_ctl_pkg;
    // Timing
    localparam int CLK_MHZ      = 25;
    localparam int LOCK_TIME_NS = 10000;
    localparam int LOCK_CYC     = (LOCK_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int REF_TO_NS    = 2000;
    localparam int REF_TO_CYC   = REF_TO_NS * CLK_MHZ / 1000;
    localparam int CNT_W        = 12;
    // Loop settings word, written over the bus or shifted in serially
    localparam int CFG_W   = 17;
    localparam int OD_LSB  = 0;
    localparam int OD_W    = 3;
    localparam int FB_LSB  = 3;
    localparam int FB_W    = 2;
    localparam int FBX_BIT = 5;
    localparam int DLY_BIT = 6;
    localparam int SRC_LSB = 7;
    localparam int SRC_W   = 2;
    localparam int PH_LSB  = 9;
    localparam int PH_W    = 8;
    localparam logic [OD_W-1:0]  OD_MAX  = 3'h6;
    localparam logic [SRC_W-1:0] SRC_PIN = 2'h0;
    localparam logic [SRC_W-1:0] SRC_OSC = 2'h1;
    localparam logic [CFG_W-1:0] CFG_RST = 17'h00008;
    // Control register bits
    localparam int CTRL_W  = 3;
    localparam int BYP_BIT = 0;
    localparam int HA_BIT  = 1;
    localparam int HB_BIT  = 2;
    // Event bits of the status, mask and clear registers
    localparam int EV_W      = 3;
    localparam int EV_LOCK   = 0;
    localparam int EV_UNLOCK = 1;
    localparam int EV_LOAD   = 2;
    // Register byte addresses
    localparam logic [7:0] A_CTRL  = 8'h00;
    localparam logic [7:0] A_CFG   = 8'h04;
    localparam logic [7:0] A_STAT  = 8'h08;
    localparam logic [7:0] A_ISTAT = 8'h0C;
    localparam logic [7:0] A_IMASK = 8'h10;
    localparam logic [7:0] A_RPER  = 8'h14;
    localparam logic [7:0] A_SHIFT = 8'h18;
endpackage

// ===== core/pll_clock_synth_control.sv
// Control and status logic of the on-chip clock synthesis loop
// Functional notes
// R01 - Output divider takes any power of two from 1 to 64.
// R02 - Passthrough select 0 drives synthesized clock, 1 drives the reference clock.
// R03 - Lock output rises once aligned and falls whenever lock is lost.
// R04 - Reference comes from pin, internal oscillator or fabric routing, user chosen.
// R05 - Feedback divider ratio multiplies the reference frequency.
// R06 - Offchip feedback input is used only when external feedback is selected.
// R07 - Fine delay input is honoured only in runtime delay mode.
// R08 - Output phase can be shifted, fixed by setting or changed at run time.
// R09 - Phase change on the feedback output may drop lock; user waits for relock.
// R10 - Enabled hold input freezes outputs at their last level.
// R11 - Fabric output clock equals the global output clock.
// R12 - User logic shifts new settings in serially on its shift clock.
// R13 - After shifting, user pulses loop reset low; loop relocks with new settings.
// R14 - One bit taken per shift clock rise; applied only at the next reset pulse.
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module pll_clock_synth_control #(
    parameter int LOCK_CYCLES = pll_ctl_pkg::LOCK_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ref_pin_in,
    input  wire logic        ref_osc_in,
    input  wire logic        ref_fabric_in,
    input  wire logic        offchip_feedback_in,
    input  wire logic [7:0]  fine_delay_adjust,
    input  wire logic        low_power_hold,
    input  wire logic        reconfig_shift_clk,
    input  wire logic        reconfig_serial_in,
    input  wire logic        loop_reset_n,
    output logic             synth_clock_global_out,
    output logic             synth_clock_fabric_out,
    output logic             lock_out,
    output logic             irq
);
    localparam int CW = pll_ctl_pkg::CNT_W;
    localparam logic [CW-1:0] LOCK_LIM = LOCK_CYCLES[CW-1:0];
    localparam logic [CW-1:0] REF_TO = pll_ctl_pkg::REF_TO_CYC[CW-1:0];

    typedef struct packed {
        logic [2:0]                     rs1;
        logic [2:0]                     rs2;
        logic                           fb1;
        logic                           fb2;
        logic [7:0]                     fd1;
        logic [7:0]                     fd2;
        logic                           lp1;
        logic                           lp2;
        logic                           sk1;
        logic                           sk2;
        logic                           sk3;
        logic                           sd1;
        logic                           sd2;
        logic                           rn1;
        logic                           rn2;
        logic                           rn3;
        logic                           ref_q;
        logic                           fbx_q;
        logic [pll_ctl_pkg::CTRL_W-1:0] ctrl;
        logic [pll_ctl_pkg::CFG_W-1:0]  cfg;
        logic [pll_ctl_pkg::CFG_W-1:0]  shf;
        logic [CW-1:0]                  per;
        logic [CW-1:0]                  pcnt;
        logic [7:0]                     ph_q;
        logic [7:0]                     ph_cnt;
        logic                           align;
        logic [CW-1:0]                  hcnt;
        logic                           syn;
        logic [6:0]                     dcnt;
        logic                           dclk;
        logic                           fb_seen;
        logic [CW-1:0]                  lcnt;
        logic                           lock;
        logic [pll_ctl_pkg::EV_W-1:0]   ist;
        logic [pll_ctl_pkg::EV_W-1:0]   imask;
        logic                           go;
        logic                           fo;
        logic                           irq;
        logic [31:0]                    rdata;
        logic                           rdy;
        logic                           err;
    } st_s;

    st_s st_r;
    st_s st_nxt;

    logic                  ref_lvl;
    logic                  ref_rise;
    logic                  fb_edge;
    logic                  syn_tog;
    logic                  sk_rise;
    logic                  cfg_load;
    logic                  lrst;
    logic                  hold;
    logic                  unlock;
    logic                  acc_done;
    logic                  fb_ext;
    logic                  dly_dyn;
    logic [2:0]            od_sel;
    logic [2:0]            od;
    logic [1:0]            fb_sel;
    logic [1:0]            src_sel;
    logic [7:0]            ph_static;
    logic [7:0]            ph;
    logic [CW-1:0]         half;
    logic [6:0]            ndiv;
    localparam int EV_BITS = pll_ctl_pkg::EV_W;

    logic [31:0]           rd;
    logic [EV_BITS-1:0]    ev;
    logic [EV_BITS-1:0]    w1c;
    logic                  clk_src;
    logic                  realign;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        st_nxt = st_r;
        // Two-stage synchronisers for everything from outside pclk
        st_nxt.rs1 = {ref_fabric_in, ref_osc_in, ref_pin_in};
        st_nxt.rs2 = st_r.rs1;
        st_nxt.fb1 = offchip_feedback_in;
        st_nxt.fb2 = st_r.fb1;
        // Fine delay bits may skew by a cycle while they change
        st_nxt.fd1 = fine_delay_adjust;
        st_nxt.fd2 = st_r.fd1;
        st_nxt.lp1 = low_power_hold;
        st_nxt.lp2 = st_r.lp1;
        st_nxt.sk1 = reconfig_shift_clk;
        st_nxt.sk2 = st_r.sk1;
        st_nxt.sk3 = st_r.sk2;
        st_nxt.sd1 = reconfig_serial_in;
        st_nxt.sd2 = st_r.sd1;
        st_nxt.rn1 = loop_reset_n;
        st_nxt.rn2 = st_r.rn1;
        st_nxt.rn3 = st_r.rn2;

        od_sel    = st_r.cfg[pll_ctl_pkg::OD_LSB +: pll_ctl_pkg::OD_W];
        fb_sel    = st_r.cfg[pll_ctl_pkg::FB_LSB +: pll_ctl_pkg::FB_W];
        fb_ext    = st_r.cfg[pll_ctl_pkg::FBX_BIT];
        dly_dyn   = st_r.cfg[pll_ctl_pkg::DLY_BIT];
        src_sel   = st_r.cfg[pll_ctl_pkg::SRC_LSB +: pll_ctl_pkg::SRC_W];
        ph_static = st_r.cfg[pll_ctl_pkg::PH_LSB +: pll_ctl_pkg::PH_W];

        case (src_sel) // see R04
            pll_ctl_pkg::SRC_PIN: ref_lvl = st_r.rs2[0];
            pll_ctl_pkg::SRC_OSC: ref_lvl = st_r.rs2[1];
            default:              ref_lvl = st_r.rs2[2];
        endcase
        st_nxt.ref_q = ref_lvl;
        ref_rise = ref_lvl & ~st_r.ref_q;
        sk_rise  = st_r.sk2 & ~st_r.sk3;
        cfg_load = st_r.rn3 & ~st_r.rn2;
        lrst     = ~st_r.rn2;
        hold     = st_r.ctrl[pll_ctl_pkg::HA_BIT] & st_r.ctrl[pll_ctl_pkg::HB_BIT]
                   & st_r.lp2;
        ph   = dly_dyn ? st_r.fd2 : ph_static; // see R07, R08
        od   = (od_sel > pll_ctl_pkg::OD_MAX) ? pll_ctl_pkg::OD_MAX : od_sel;
        ndiv = 7'h01 << od; // see R01
        // Multiply by 2**fb_sel: half period of the synthesized clock
        half = st_r.per >> ({1'b0, fb_sel} + 3'h1); // see R05
        if (half == '0) begin
            half = {{(CW-1){1'b0}}, 1'b1};
        end

        // Reference period in pclk cycles
        if (ref_rise) begin
            st_nxt.per  = st_r.pcnt;
            st_nxt.pcnt = {{(CW-1){1'b0}}, 1'b1};
        end else if (st_r.pcnt != '1) begin
            st_nxt.pcnt = st_r.pcnt + 1'b1;
        end

        ////////////////////////////////////////////////////////////////
        // Synthesized clock, re-aligned at each reference edge plus phase
        syn_tog = 1'b0;
        realign = 1'b0;
        if (lrst) begin
            st_nxt.syn   = 1'b0;
            st_nxt.hcnt  = '0;
            st_nxt.align = 1'b0;
            st_nxt.dcnt  = '0;
            st_nxt.dclk  = 1'b0;
        end else begin
            if (ref_rise) begin
                st_nxt.align  = 1'b1;
                st_nxt.ph_cnt = ph; // see R08
            end else if (st_r.align) begin
                // A phase beyond one reference period is never reached
                if (st_r.ph_cnt == 8'h00) begin
                    st_nxt.align = 1'b0;
                    realign      = 1'b1;
                end else begin
                    st_nxt.ph_cnt = st_r.ph_cnt - 8'h01;
                end
            end
            // Free run goes on while the phase counts down, so no period is lost
            if (realign) begin
                st_nxt.syn  = 1'b1;
                st_nxt.hcnt = '0;
                syn_tog     = ~st_r.syn;
            end else if (st_r.hcnt >= half - 1'b1) begin
                st_nxt.syn  = ~st_r.syn;
                st_nxt.hcnt = '0;
                syn_tog     = 1'b1;
            end else begin
                st_nxt.hcnt = st_r.hcnt + 1'b1;
            end
            if (syn_tog) begin
                if (st_r.dcnt >= ndiv - 7'h01) begin // see R01
                    st_nxt.dclk = ~st_r.dclk;
                    st_nxt.dcnt = '0;
                end else begin
                    st_nxt.dcnt = st_r.dcnt + 7'h01;
                end
            end
        end

        ////////////////////////////////////////////////////////////////
        // Lock detector
        st_nxt.fbx_q = st_r.fb2;
        fb_edge = fb_ext ? (st_r.fb2 & ~st_r.fbx_q) // see R06
                         : (syn_tog & ~st_r.syn);
        if (ref_rise) begin
            st_nxt.fb_seen = fb_edge;
        end else if (fb_edge) begin
            st_nxt.fb_seen = 1'b1;
        end
        st_nxt.ph_q = ph;
        // Phase moved on the output that feeds back: start over
        unlock = lrst | (ref_rise & ~st_r.fb_seen) | (st_r.pcnt >= REF_TO)
                 | (~fb_ext & (ph != st_r.ph_q)); // see R09
        if (unlock) begin
            st_nxt.lcnt = '0;
            st_nxt.lock = 1'b0; // see R03
        end else if (st_r.lcnt != LOCK_LIM) begin
            st_nxt.lcnt = st_r.lcnt + 1'b1;
        end else begin
            st_nxt.lock = 1'b1; // see R03
        end

        // Shift port, held aside until the loop reset pulse
        if (sk_rise) begin
            st_nxt.shf = {st_r.shf[pll_ctl_pkg::CFG_W-2:0], st_r.sd2}; // see R14
        end

        ////////////////////////////////////////////////////////////////
        // APB slave: one wait state; writes land at the completing edge
        acc_done = psel & penable & st_r.rdy;
        st_nxt.rdy = psel & penable & ~st_r.rdy;
        rd = 32'h0000_0000;
        w1c = '0;
        case (paddr)
            pll_ctl_pkg::A_CTRL:  rd[pll_ctl_pkg::CTRL_W-1:0] = st_r.ctrl;
            pll_ctl_pkg::A_CFG:   rd[pll_ctl_pkg::CFG_W-1:0] = st_r.cfg;
            pll_ctl_pkg::A_STAT:  rd[2:0] = {hold, lrst, st_r.lock};
            pll_ctl_pkg::A_ISTAT: rd[EV_BITS-1:0] = st_r.ist;
            pll_ctl_pkg::A_IMASK: rd[EV_BITS-1:0] = st_r.imask;
            pll_ctl_pkg::A_RPER:  rd[CW-1:0] = st_r.per;
            pll_ctl_pkg::A_SHIFT: rd[pll_ctl_pkg::CFG_W-1:0] = st_r.shf;
            default:              rd = 32'h0000_0000;
        endcase
        if (psel & penable & ~st_r.rdy) begin
            st_nxt.rdata = pwrite ? 32'h0000_0000 : rd;
            st_nxt.err = (paddr > pll_ctl_pkg::A_SHIFT) | (paddr[1:0] != 2'h0);
        end
        if (acc_done & pwrite & ~st_r.err) begin
            case (paddr)
                pll_ctl_pkg::A_CTRL:
                    st_nxt.ctrl = pwdata[pll_ctl_pkg::CTRL_W-1:0];
                pll_ctl_pkg::A_CFG:
                    st_nxt.cfg = pwdata[pll_ctl_pkg::CFG_W-1:0];
                pll_ctl_pkg::A_ISTAT:
                    w1c = pwdata[EV_BITS-1:0];
                pll_ctl_pkg::A_IMASK:
                    st_nxt.imask = pwdata[EV_BITS-1:0];
                default: ;
            endcase
        end
        if (cfg_load) begin
            st_nxt.cfg = st_r.shf; // see R13, R14
        end

        // Sticky events; a new event beats a clear in the same cycle
        ev = '0;
        ev[pll_ctl_pkg::EV_LOCK]   = st_nxt.lock & ~st_r.lock;
        ev[pll_ctl_pkg::EV_UNLOCK] = ~st_nxt.lock & st_r.lock;
        ev[pll_ctl_pkg::EV_LOAD]   = cfg_load;
        st_nxt.ist = (st_r.ist & ~w1c) | ev;
        st_nxt.irq = |(st_nxt.ist & st_nxt.imask);

        // Output clocks: both copies from one source so they never differ
        clk_src = st_r.ctrl[pll_ctl_pkg::BYP_BIT] ? ref_lvl : st_r.dclk; // see R02
        if (!hold) begin // see R10
            st_nxt.go = clk_src;
            st_nxt.fo = clk_src; // see R11
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r       <= '0;
            st_r.rn1   <= 1'b1;
            st_r.rn2   <= 1'b1;
            st_r.rn3   <= 1'b1;
            st_r.cfg   <= pll_ctl_pkg::CFG_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata                 = st_r.rdata;
    assign pready                 = st_r.rdy;
    assign pslverr                = st_r.rdy & st_r.err;
    assign synth_clock_global_out = st_r.go;
    assign synth_clock_fabric_out = st_r.fo;
    assign lock_out               = st_r.lock;
    assign irq                    = st_r.irq;

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_reload;
        st_r.rn3 && !st_r.rn2;
    endsequence
    sequence s_shift;
        st_r.sk2 && !st_r.sk3;
    endsequence

    chk_bypass_mux: assert property ( // see R02
        !hold && st_r.ctrl[pll_ctl_pkg::BYP_BIT] |=> st_r.go == $past(ref_lvl))
        else $error("bypass output does not follow reference");
    chk_out_match: assert property ( // see R11
        st_r.go == st_r.fo)
        else $error("fabric and global clocks differ");
    chk_lock_drop: assert property ( // see R03
        ref_rise && !st_r.fb_seen |=> !st_r.lock ##1 !st_r.lock)
        else $error("lock held without feedback");
    chk_lock_time: assert property ( // see R03
        $rose(st_r.lock) |-> $past(st_r.lcnt) == LOCK_LIM)
        else $error("lock rose before the acquire time");
    chk_phase_unlock: assert property ( // see R09
        !fb_ext && ph != st_r.ph_q && !cfg_load |=> !st_r.lock && st_r.lcnt == '0)
        else $error("phase move on feedback output kept lock");
    chk_hold_freeze: assert property ( // see R10
        hold |=> st_r.go == $past(st_r.go) && st_r.fo == $past(st_r.fo))
        else $error("output moved while held");
    chk_delay_ignore: assert property ( // see R07
        !dly_dyn |=> st_r.ph_q == $past(ph_static))
        else $error("fine delay used in static mode");
    chk_shift_cap: assert property ( // see R14
        s_shift |=> st_r.shf[0] == $past(st_r.sd2))
        else $error("shift bit not captured");
    chk_cfg_reload: assert property ( // see R13
        s_reload |=> st_r.cfg == $past(st_r.shf) && !st_r.lock)
        else $error("shifted settings not applied at reset pulse");
    chk_div_range: assert property ( // see R01
        syn_tog && !lrst && st_r.dcnt >= ndiv - 7'h01 |=> st_r.dclk != $past(st_r.dclk))
        else $error("divided clock missed its toggle");
endmodule

// ===== core/unused_placeholder_removed.sv
// Intentionally empty: no further design content
`timescale 1ns/1ns

// ===== sim/fabric_user_model.sv
// Fabric-side user logic model: reference clocks and reconfiguration port
`timescale 1ns/1ns
module fabric_user_model (
    input  wire logic ref_run,
    output logic      ref_pin_in,
    output logic      ref_osc_in,
    output logic      ref_fabric_in,
    output logic      offchip_feedback_in,
    output logic      reconfig_shift_clk,
    output logic      reconfig_serial_in,
    output logic      loop_reset_n
);
    initial begin
        ref_pin_in = 1'b0;
        ref_osc_in = 1'b0;
        ref_fabric_in = 1'b0;
        offchip_feedback_in = 1'b0;
        reconfig_shift_clk = 1'b0;
        reconfig_serial_in = 1'b0;
        loop_reset_n = 1'b1;
    end
    // Pin reference stands still when stopped, to provoke loss of lock
    always begin
        #160;
        if (ref_run) begin
            ref_pin_in = ~ref_pin_in;
        end
    end
    always #250 ref_osc_in = ~ref_osc_in;
    always #200 ref_fabric_in = ~ref_fabric_in;
    // Shift clock only runs inside a frame
    task automatic shift_word(input logic [16:0] w);
        // Keep clear of the pclk sampling edge
        #10;
        for (int i = 16; i >= 0; i--) begin
            reconfig_serial_in = w[i];
            #80 reconfig_shift_clk = 1'b1;
            #160 reconfig_shift_clk = 1'b0;
            #80;
        end
        reconfig_serial_in = ~w[0];
    endtask
    task automatic pulse_reset();
        #10;
        loop_reset_n = 1'b0;
        #400 loop_reset_n = 1'b1;
    endtask
endmodule

// ===== sim/tb_pll_clock_synth_control.sv
// Self-checking bench of the clock synthesis control block
`timescale 1ns/1ns
module tb_pll_clock_synth_control;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ref_pin_in, ref_osc_in, ref_fabric_in, offchip_feedback_in;
    logic        reconfig_shift_clk, reconfig_serial_in, loop_reset_n;
    logic [7:0]  fine_delay_adjust = 8'h00;
    logic        low_power_hold = 1'b0;
    logic        ref_run = 1'b1;
    logic        glob, fab, lock_out, irq;
    int          err_total = 0;
    int          checked = 0;
    int          exp_cnt [4] = '{64, 128, 16, 1};
    logic [31:0] div_cfg [4] = '{32'h08, 32'h10, 32'h0A, 32'h0E};

    always #20 pclk = ~pclk;

    fabric_user_model pm (.ref_run(ref_run), .ref_pin_in(ref_pin_in),
        .ref_osc_in(ref_osc_in), .ref_fabric_in(ref_fabric_in),
        .offchip_feedback_in(offchip_feedback_in),
        .reconfig_shift_clk(reconfig_shift_clk),
        .reconfig_serial_in(reconfig_serial_in), .loop_reset_n(loop_reset_n));

    pll_clock_synth_control #(.LOCK_CYCLES(16)) uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ref_pin_in(ref_pin_in), .ref_osc_in(ref_osc_in),
        .ref_fabric_in(ref_fabric_in), .offchip_feedback_in(offchip_feedback_in),
        .fine_delay_adjust(fine_delay_adjust), .low_power_hold(low_power_hold),
        .reconfig_shift_clk(reconfig_shift_clk),
        .reconfig_serial_in(reconfig_serial_in), .loop_reset_n(loop_reset_n),
        .synth_clock_global_out(glob), .synth_clock_fabric_out(fab),
        .lock_out(lock_out), .irq(irq));

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            end_sim();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        check(nm, q & m, exp);
    endtask
    // Bounded wait for a lock level
    task automatic wl(input logic v, input int n);
        int i;
        i = 0;
        while (lock_out !== v && i < n) begin
            @(posedge pclk);
            i++;
        end
        check("lock", {31'h0, lock_out}, {31'h0, v});
        if (lock_out !== v) begin
            end_sim();
        end
    endtask
    // Rising edges of the global output in 256 cycles
    task automatic cnt(output int c);
        int   m;
        logic p;
        c = 0;
        m = 0;
        p = glob;
        repeat (256) begin
            @(posedge pclk);
            if (glob === 1'b1 && p === 1'b0) c++;
            if (fab !== glob) m++;
            p = glob;
        end
        check("fabric_eq", m, 0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [31:0] q;
        logic        e;
        rdc("ctrl", pll_ctl_pkg::A_CTRL, 32'hFFFFFFFF, 32'h0);
        rdc("cfg", pll_ctl_pkg::A_CFG, 32'hFFFFFFFF, 32'(pll_ctl_pkg::CFG_RST));
        rdc("mask", pll_ctl_pkg::A_IMASK, 32'hFFFFFFFF, 32'h0);
        apb(1'b0, 8'h1C, 32'h0, q, e);
        check("unmapped", {q[30:0], e}, 32'h1);
    endtask
    task automatic t_clocks();
        int c;
        for (int k = 0; k < 4; k++) begin
            wr(pll_ctl_pkg::A_CFG, div_cfg[k]);
            cnt(c);
            check("freq", 32'(c >= exp_cnt[k] - 1 && c <= exp_cnt[k] + 1), 32'h1);
        end
        wr(pll_ctl_pkg::A_CFG, 32'h08);
        wr(pll_ctl_pkg::A_CTRL, 32'h1);
        cnt(c);
        check("bypass", 32'(c >= 31 && c <= 33), 32'h1);
        wr(pll_ctl_pkg::A_CTRL, 32'h0);
    endtask
    task automatic t_hold();
        int c;
        low_power_hold <= 1'b1;
        wr(pll_ctl_pkg::A_CTRL, 32'h6);
        repeat (8) @(posedge pclk);
        cnt(c);
        check("held", c, 0);
        rdc("hold_stat", pll_ctl_pkg::A_STAT, 32'h4, 32'h4);
        wr(pll_ctl_pkg::A_CTRL, 32'h2);
        cnt(c);
        check("not_held", 32'(c > 0), 32'h1);
        low_power_hold <= 1'b0;
        wr(pll_ctl_pkg::A_CTRL, 32'h0);
    endtask
    task automatic t_delay();
        fine_delay_adjust <= 8'h03;
        repeat (12) @(posedge pclk);
        check("dly_static", {31'h0, lock_out}, 32'h1);
        wr(pll_ctl_pkg::A_CFG, 32'h48);
        wl(1'b0, 20);
        wl(1'b1, 400);
    endtask
    task automatic t_reconfig();
        wr(pll_ctl_pkg::A_CFG, 32'h28);
        wl(1'b0, 100);
        wr(pll_ctl_pkg::A_CFG, 32'h08);
        wl(1'b1, 400);
        wr(pll_ctl_pkg::A_IMASK, 32'h4);
        pm.shift_word(17'h00009);
        repeat (4) @(posedge pclk);
        rdc("shift", pll_ctl_pkg::A_SHIFT, 32'h1FFFF, 32'h9);
        rdc("cfg_old", pll_ctl_pkg::A_CFG, 32'h1FFFF, 32'h8);
        pm.pulse_reset();
        rdc("cfg_new", pll_ctl_pkg::A_CFG, 32'h1FFFF, 32'h9);
        check("irq_set", {31'h0, irq}, 32'h1);
        wr(pll_ctl_pkg::A_ISTAT, 32'h7);
        repeat (2) @(posedge pclk);
        check("irq_clr", {31'h0, irq}, 32'h0);
        wl(1'b1, 400);
    endtask
    task automatic t_unlock();
        ref_run <= 1'b0;
        wl(1'b0, 100);
        rdc("lost_ev", pll_ctl_pkg::A_ISTAT, 32'h2, 32'h2);
        wr(pll_ctl_pkg::A_CFG, 32'h108);
        wl(1'b1, 600);
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        wl(1'b1, 400);
        rdc("lock_ev", pll_ctl_pkg::A_ISTAT, 32'h1, 32'h1);
        t_clocks();
        t_hold();
        t_delay();
        t_reconfig();
        t_unlock();
        end_sim();
    end
endmodule
